// ===== hw/transfer_controller_top.sv
// eight-channel mover between peripheral registers and DMA RAM, AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none

module transfer_controller_top (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite register slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// peripheral request lines and indirect offset
	input wire logic [127:0] peripheral_request_line,
	input wire logic [15:0] periph_indirect_offset,
	// private bus toward DMA RAM
	output transfer_controller_pkg::transfer_controller_access_s ram_access,
	input wire logic [15:0] ram_rdata,
	// private bus toward peripheral registers
	output transfer_controller_pkg::transfer_controller_access_s periph_access,
	input wire logic [15:0] periph_rdata,
	// per-channel block or half-block interrupt requests, chosen by CON_HALF_IRQ
	output logic [7:0] channel_irq
);
	import transfer_controller_pkg::*;

	transfer_controller_state_s s;
	transfer_controller_state_s next_s;

	// combinational scratch
	logic found;
	logic [2:0] c;
	logic [2:0] rc;
	logic [2:0] rg;
	logic [15:0] addr;
	logic [15:0] data;
	logic [15:0] wv;
	logic [15:0] rv;
	logic [15:0] step;
	logic [10:0] half_point;
	logic one_shot_stop;

	// per-channel request selection, edge and readiness, read by the engine and the trigger logic
	logic [TRANSFER_CONTROLLER_CHANNELS-1:0] sel_line;
	logic [TRANSFER_CONTROLLER_CHANNELS-1:0] line_rise;
	logic [TRANSFER_CONTROLLER_CHANNELS-1:0] chan_ready;

	for (genvar g = 0; g < TRANSFER_CONTROLLER_CHANNELS; g++) begin : g_chan
		assign sel_line[g] = peripheral_request_line[s.req[g][6:0]];
		assign line_rise[g] = sel_line[g] && !s.line_prev[g];
		assign chan_ready[g] = s.con[g][CON_CHANNEL_ON] && (s.pend[g] || s.req[g][REQ_FORCE]);
	end

	always_comb begin
		next_s = s;
		found = 1'b0;
		c = 3'h0;
		rc = 3'h0;
		rg = 3'h0;
		addr = 16'h0000;
		data = 16'h0000;
		wv = 16'h0000;
		rv = 16'h0000;
		step = STEP_WORD;
		half_point = 11'h000;
		one_shot_stop = 1'b0;
		next_s.ram.re = 1'b0;
		next_s.ram.we = 1'b0;
		next_s.per.re = 1'b0;
		next_s.per.we = 1'b0;
		next_s.irq = '0;

		// transfer engine on the private bus
		case (s.st)
			ST_IDLE: begin
				// lowest-numbered ready channel wins
				for (int i = TRANSFER_CONTROLLER_CHANNELS - 1; i >= 0; i--) begin
					if (chan_ready[i]) begin
						found = 1'b1;
						c = 3'(i);
					end
				end
				if (found) begin
					if (s.con[c][CON_SCHEME_LSB +: 2] == SCHEME_PERIPH_INDIRECT) begin
						addr = s.primary_ram_base[c] | periph_indirect_offset;
					end else begin
						addr = s.cur[c];
					end
					next_s.ch = c;
					next_s.xaddr = addr;
					next_s.last_ch = {1'b0, c};
					if (s.con[c][CON_RAM_TO_PERIPH]) begin
						next_s.ram.re = 1'b1;
						next_s.ram.addr = addr;
						next_s.ram.byte_size = s.con[c][CON_BYTE_SIZE];
					end else begin
						next_s.per.re = 1'b1;
						next_s.per.addr = s.pad[c];
						next_s.per.byte_size = s.con[c][CON_BYTE_SIZE];
					end
					next_s.st = ST_CAPTURE;
				end
			end
			ST_CAPTURE: begin
				// read strobe is out this cycle, data returns in the next
				next_s.st = ST_WRITE;
			end
			ST_WRITE: begin
				c = s.ch;
				data = s.con[c][CON_RAM_TO_PERIPH] ? ram_rdata : periph_rdata;
				if (s.con[c][CON_BYTE_SIZE]) begin
					data = data & BYTE_LANE;
					step = STEP_BYTE;
				end
				if (s.con[c][CON_RAM_TO_PERIPH]) begin
					next_s.per.we = 1'b1;
					next_s.per.addr = s.pad[c];
					next_s.per.wdata = data;
					next_s.per.byte_size = s.con[c][CON_BYTE_SIZE];
				end else begin
					next_s.ram.we = 1'b1;
					next_s.ram.addr = s.xaddr;
					next_s.ram.wdata = data;
					next_s.ram.byte_size = s.con[c][CON_BYTE_SIZE];
					if (s.con[c][CON_DUMMY_WRITE]) begin
						next_s.per.we = 1'b1;
						next_s.per.addr = s.pad[c];
						next_s.per.wdata = 16'h0000;
						next_s.per.byte_size = s.con[c][CON_BYTE_SIZE];
					end
				end
				if (s.con[c][CON_SCHEME_LSB +: 2] == SCHEME_POST_INC) begin
					next_s.cur[c] = s.cur[c] + step;
				end
				if (s.req[c][REQ_FORCE]) begin
					next_s.req[c][REQ_FORCE] = 1'b0;
				end else begin
					next_s.pend[c] = 1'b0;
				end
				// half point rounds up, so an odd block never signals before half has moved
				half_point = (11'({1'b0, s.len[c]}) + 11'h002) >> 1;
				if (s.done_cnt[c] == s.len[c]) begin
					next_s.done_cnt[c] = 10'h000;
					if (!s.con[c][CON_HALF_IRQ]) begin
						next_s.irq[c] = 1'b1;
					end
					one_shot_stop = !s.con[c][CON_MODE_PING_PONG] || s.pp[c];
					if (s.con[c][CON_MODE_ONE_SHOT] && one_shot_stop) begin
						next_s.con[c][CON_CHANNEL_ON] = 1'b0;
					end
					if (s.con[c][CON_MODE_PING_PONG]) begin
						next_s.pp[c] = ~s.pp[c];
						next_s.cur[c] = s.pp[c] ? s.primary_ram_base[c] : s.stb[c];
					end else begin
						next_s.cur[c] = s.primary_ram_base[c];
					end
				end else begin
					next_s.done_cnt[c] = s.done_cnt[c] + 10'h001;
					if (s.con[c][CON_HALF_IRQ]
						&& (11'({1'b0, s.done_cnt[c]}) + 11'h001) == half_point) begin
						next_s.irq[c] = 1'b1;
					end
				end
				next_s.st = ST_IDLE;
			end
			default: begin
				next_s.st = ST_IDLE;
			end
		endcase

		// register slave: address phase, then one wait cycle, then the answer
		if (hsel && hready && htrans[1]) begin
			next_s.bus_pend = 1'b1;
			next_s.bus_write = hwrite;
			next_s.bus_addr = haddr[8:0];
			next_s.bus_mapped = (haddr[31:9] == 23'h000000) && (haddr[1:0] == 2'h0)
				&& (hsize == TRANSFER_CONTROLLER_HSIZE_WORD)
				&& (!haddr[8] || (haddr[7:3] == 5'h00))
				&& (haddr[8] || (haddr[4:2] <= TRANSFER_CONTROLLER_REG_LENGTH));
			next_s.hreadyout = 1'b0;
		end
		if (s.bus_pend) begin
			next_s.bus_pend = 1'b0;
			next_s.hreadyout = 1'b1;
			rc = s.bus_addr[7:5];
			rg = s.bus_addr[4:2];
			wv = hwdata[15:0];
			if (!s.bus_mapped) begin
				rv = 16'h0000;
			end else if (s.bus_addr == TRANSFER_CONTROLLER_SHARED_STATUS_ZERO) begin
				rv = {s.col_per, s.col_ram};
				if (s.bus_write) begin
					// writing zero clears a flag
					next_s.col_per = s.col_per & wv[15:8];
					next_s.col_ram = s.col_ram & wv[7:0];
				end
			end else if (s.bus_addr == TRANSFER_CONTROLLER_SHARED_STATUS_ONE) begin
				rv = {4'h0, s.last_ch, s.pp};
			end else begin
				case (rg)
					TRANSFER_CONTROLLER_REG_CONTROL: begin
						rv = s.con[rc];
						if (s.bus_write) begin
							next_s.con[rc] = wv & CON_WRITE_MASK;
							if (wv[CON_CHANNEL_ON] && !s.con[rc][CON_CHANNEL_ON]) begin
								next_s.cur[rc] = s.primary_ram_base[rc];
								next_s.done_cnt[rc] = 10'h000;
								next_s.pp[rc] = 1'b0;
							end
						end
					end
					TRANSFER_CONTROLLER_REG_REQUEST: begin
						rv = s.req[rc];
						if (s.bus_write) begin
							next_s.req[rc] = (wv & REQ_SELECT_MASK)
								| {next_s.req[rc][REQ_FORCE] | wv[REQ_FORCE], 15'h0000};
						end
					end
					TRANSFER_CONTROLLER_REG_PRIMARY: begin
						rv = s.primary_ram_base[rc];
						if (s.bus_write) begin
							next_s.primary_ram_base[rc] = wv;
						end
					end
					TRANSFER_CONTROLLER_REG_SECONDARY: begin
						rv = s.stb[rc];
						if (s.bus_write) begin
							next_s.stb[rc] = wv;
						end
					end
					TRANSFER_CONTROLLER_REG_PERIPH_ADDR: begin
						rv = s.pad[rc];
						if (s.bus_write) begin
							next_s.pad[rc] = wv;
						end
					end
					TRANSFER_CONTROLLER_REG_LENGTH: begin
						rv = {6'h00, s.len[rc]};
						if (s.bus_write) begin
							next_s.len[rc] = wv[9:0];
						end
					end
					default: begin
						rv = 16'h0000;
					end
				endcase
			end
			if (!s.bus_write) begin
				next_s.hrdata = {16'h0000, rv};
			end
		end

		// trigger detection last, so a new request survives a same-cycle clear
		for (int i = 0; i < TRANSFER_CONTROLLER_CHANNELS; i++) begin
			next_s.line_prev[i] = sel_line[i];
			if (line_rise[i]) begin
				if (s.pend[i]) begin
					if (s.con[i][CON_RAM_TO_PERIPH]) begin
						next_s.col_per[i] = 1'b1;
					end else begin
						next_s.col_ram[i] = 1'b1;
					end
				end
				next_s.pend[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.last_ch <= LAST_CHANNEL_NONE;
			s.hreadyout <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign hreadyout = s.hreadyout;
	assign hresp = s.hresp;
	assign hrdata = s.hrdata;
	assign ram_access = s.ram;
	assign periph_access = s.per;
	assign channel_irq = s.irq;

endmodule // transfer_controller_top

`default_nettype wire

// ===== hw/transfer_controller_pkg.sv
// package: register map, field positions, carrier structs and state of the eight-channel mover
package transfer_controller_pkg;

	localparam int unsigned TRANSFER_CONTROLLER_CHANNELS = 8;

	// byte addresses: each channel owns a 0x20 slot, the shared status pair sits above
	localparam logic [8:0] TRANSFER_CONTROLLER_CH_STRIDE = 9'h020;
	localparam logic [2:0] TRANSFER_CONTROLLER_REG_CONTROL = 3'h0;
	localparam logic [2:0] TRANSFER_CONTROLLER_REG_REQUEST = 3'h1;
	localparam logic [2:0] TRANSFER_CONTROLLER_REG_PRIMARY = 3'h2;
	localparam logic [2:0] TRANSFER_CONTROLLER_REG_SECONDARY = 3'h3;
	localparam logic [2:0] TRANSFER_CONTROLLER_REG_PERIPH_ADDR = 3'h4;
	localparam logic [2:0] TRANSFER_CONTROLLER_REG_LENGTH = 3'h5;
	localparam logic [8:0] TRANSFER_CONTROLLER_SHARED_STATUS_ZERO = 9'h100;
	localparam logic [8:0] TRANSFER_CONTROLLER_SHARED_STATUS_ONE = 9'h104;
	localparam logic [2:0] TRANSFER_CONTROLLER_HSIZE_WORD = 3'h2;

	// channel_control fields
	localparam int unsigned CON_CHANNEL_ON = 15;
	localparam int unsigned CON_BYTE_SIZE = 14;
	localparam int unsigned CON_RAM_TO_PERIPH = 13;
	localparam int unsigned CON_HALF_IRQ = 12;
	localparam int unsigned CON_DUMMY_WRITE = 11;
	localparam int unsigned CON_SCHEME_LSB = 4;
	localparam int unsigned CON_MODE_ONE_SHOT = 0;
	localparam int unsigned CON_MODE_PING_PONG = 1;
	localparam logic [15:0] CON_WRITE_MASK = 16'hF833;

	// channel_request_select fields
	localparam int unsigned REQ_FORCE = 15;
	localparam logic [15:0] REQ_SELECT_MASK = 16'h007F;
	localparam logic [15:0] LENGTH_MASK = 16'h03FF;

	// addressing_scheme encodings
	localparam logic [1:0] SCHEME_POST_INC = 2'h0;
	localparam logic [1:0] SCHEME_FIXED = 2'h1;
	localparam logic [1:0] SCHEME_PERIPH_INDIRECT = 2'h2;

	localparam logic [3:0] LAST_CHANNEL_NONE = 4'hF;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [15:0] BYTE_LANE = 16'h00FF;

	// one access on the mover's own bus, toward DMA RAM or a peripheral register
	typedef struct packed {
		logic re;
		logic we;
		logic byte_size;
		logic [15:0] addr;
		logic [15:0] wdata;
	} transfer_controller_access_s;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CAPTURE,
		ST_WRITE
	} transfer_controller_engine_e;

	typedef struct packed {
		logic [TRANSFER_CONTROLLER_CHANNELS-1:0][15:0] con;
		logic [TRANSFER_CONTROLLER_CHANNELS-1:0][15:0] req;
		logic [TRANSFER_CONTROLLER_CHANNELS-1:0][15:0] primary_ram_base;
		logic [TRANSFER_CONTROLLER_CHANNELS-1:0][15:0] stb;
		logic [TRANSFER_CONTROLLER_CHANNELS-1:0][15:0] pad;
		logic [TRANSFER_CONTROLLER_CHANNELS-1:0][9:0] len;
		logic [TRANSFER_CONTROLLER_CHANNELS-1:0][9:0] done_cnt;
		logic [TRANSFER_CONTROLLER_CHANNELS-1:0][15:0] cur;
		logic [TRANSFER_CONTROLLER_CHANNELS-1:0] pend;
		logic [TRANSFER_CONTROLLER_CHANNELS-1:0] line_prev;
		logic [TRANSFER_CONTROLLER_CHANNELS-1:0] pp;
		logic [TRANSFER_CONTROLLER_CHANNELS-1:0] col_per;
		logic [TRANSFER_CONTROLLER_CHANNELS-1:0] col_ram;
		logic [3:0] last_ch;
		transfer_controller_engine_e st;
		logic [2:0] ch;
		logic [15:0] xaddr;
		transfer_controller_access_s ram;
		transfer_controller_access_s per;
		logic [TRANSFER_CONTROLLER_CHANNELS-1:0] irq;
		logic bus_pend;
		logic bus_write;
		logic bus_mapped;
		logic [8:0] bus_addr;
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
	} transfer_controller_state_s;

endpackage

// ===== verification/transfer_controller_far_side.sv
// far side model: DMA RAM and peripheral registers on the private buses
`timescale 1ns/1ps
`default_nettype none
module transfer_controller_far_side (
	// clock
	input wire logic hclk,
	// private buses
	input wire transfer_controller_pkg::transfer_controller_access_s ram_access,
	input wire transfer_controller_pkg::transfer_controller_access_s periph_access,
	output logic [15:0] ram_rdata = 16'h0000,
	output logic [15:0] periph_rdata = 16'h0000
);
	import transfer_controller_pkg::*;
	// data stands one cycle after a read strobe, then scrambles
	always @(posedge hclk) begin
		ram_rdata <= ram_access.re ? ram_access.addr ^ 16'hA5C3 : ~ram_rdata;
		periph_rdata <= periph_access.re ? periph_access.addr ^ 16'h3C5A : ~periph_rdata;
	end
endmodule // transfer_controller_far_side
`default_nettype wire

// ===== verification/transfer_controller_top_assertions.sv
// assertions on the register bus and private bus ports
`timescale 1ns/1ps
`default_nettype none
module transfer_controller_top_assertions (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// register bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// private buses and requests
	input wire transfer_controller_pkg::transfer_controller_access_s ram_access,
	input wire transfer_controller_pkg::transfer_controller_access_s periph_access,
	input wire logic [7:0] channel_irq
);
	import transfer_controller_pkg::*;
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	property p_wait;
		hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout;
	endproperty
	a_wait: assert property (p_wait) else $error("wait state wrong");
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_gap;
		ram_access.re || periph_access.re |=> !(ram_access.re || periph_access.re) [*2];
	endproperty
	a_gap: assert property (p_gap) else $error("reads too close");
	property p_out;
		ram_access.re |-> ##2 periph_access.we && !ram_access.we;
	endproperty
	a_out: assert property (p_out) else $error("outbound write missing");
	property p_in;
		periph_access.re |-> ##2 ram_access.we;
	endproperty
	a_in: assert property (p_in) else $error("inbound write missing");
	property p_null;
		periph_access.re ##2 periph_access.we |-> periph_access.wdata == 16'h0000;
	endproperty
	a_null: assert property (p_null) else $error("null data not zero");
	property p_byte;
		periph_access.we && periph_access.byte_size |-> periph_access.wdata[15:8] == 8'h00;
	endproperty
	a_byte: assert property (p_byte) else $error("byte not masked");
	property p_irq;
		|channel_irq |-> (ram_access.we || periph_access.we) && $onehot(channel_irq);
	endproperty
	a_irq: assert property (p_irq) else $error("irq without write");
	c_irq: cover property (|channel_irq);
	c_null: cover property (periph_access.re ##2 periph_access.we);
	c_byte: cover property (periph_access.we && periph_access.byte_size);
endmodule // transfer_controller_top_assertions
bind transfer_controller_top transfer_controller_top_assertions u_chk (
	.hclk(hclk),
	.hresetn(hresetn),
	.hsel(hsel),
	.htrans(htrans),
	.hready(hready),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.ram_access(ram_access),
	.periph_access(periph_access),
	.channel_irq(channel_irq)
);
`default_nettype wire

// ===== verification/transfer_controller_top_tb.sv
// testbench of the eight-channel mover
`timescale 1ns/1ps
`default_nettype none
module transfer_controller_top_tb;
	import transfer_controller_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [127:0] req_lines = '0;
	logic [15:0] ram_rdata;
	logic [15:0] periph_rdata;
	transfer_controller_access_s ram_access;
	transfer_controller_access_s periph_access;
	logic [7:0] channel_irq;
	int err_total = 0;
	int checks_done = 0;
	int moves = 0;
	int irqs = 0;
	logic [15:0] ram_a;
	logic [15:0] per_d;
	logic [31:0] rd;
	transfer_controller_top dut (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(TRANSFER_CONTROLLER_HSIZE_WORD),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.peripheral_request_line(req_lines),
		.periph_indirect_offset(16'h0040),
		.ram_access(ram_access),
		.ram_rdata(ram_rdata),
		.periph_access(periph_access),
		.periph_rdata(periph_rdata),
		.channel_irq(channel_irq)
	);
	transfer_controller_far_side far (
		.hclk(hclk),
		.ram_access(ram_access),
		.periph_access(periph_access),
		.ram_rdata(ram_rdata),
		.periph_rdata(periph_rdata)
	);
	initial begin
		forever #50 hclk = ~hclk;
	end
	// counts write strobes and keeps the last address and data
	always @(posedge hclk) begin
		if (ram_access.we === 1'b1) begin
			moves++;
			ram_a = ram_access.addr;
		end
		if (periph_access.we === 1'b1) begin
			moves++;
			per_d = periph_access.wdata;
		end
		if (channel_irq !== 8'h00) irqs++;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			err_total++;
			$display("ERROR hreadyout expected 1 seen %b", hreadyout);
			close_out;
		end
	endtask
	task automatic bus(input logic w, input logic [8:0] a, input logic [15:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {23'h0, a};
		hwrite <= w;
		wait_ready;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0, d};
		wait_ready;
		rd = hrdata;
	endtask
	task automatic rdchk(input logic [8:0] a, input logic [31:0] e);
		bus(1'b0, a, 16'h0);
		chk($sformatf("reg %h", a), e, rd);
	endtask
	function automatic logic [8:0] ra(input int c, input logic [2:0] r);
		return {1'b0, 3'(c), r, 2'b00};
	endfunction
	task automatic trig(input int line);
		req_lines[line] <= 1'b1;
		repeat (2) @(posedge hclk);
		req_lines[line] <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask
	task automatic wait_moves(input int want);
		int n;
		for (n = 0; n < 40 && moves < want; n++) @(posedge hclk);
		if (moves < want) begin
			err_total++;
			$display("ERROR moves expected %0d seen %0d", want, moves);
			close_out;
		end
	endtask
	task automatic t_reset;
		rdchk(ra(0, TRANSFER_CONTROLLER_REG_CONTROL), 32'h0);
		rdchk(ra(5, TRANSFER_CONTROLLER_REG_REQUEST), 32'h0);
		rdchk(ra(3, TRANSFER_CONTROLLER_REG_PRIMARY), 32'h0);
		rdchk(TRANSFER_CONTROLLER_SHARED_STATUS_ONE, 32'h0F00);
		bus(1'b1, 9'h1F8, 16'hFFFF);
		rdchk(9'h1F8, 32'h0);
		for (int c = 0; c < 8; c++) bus(1'b1, ra(c, TRANSFER_CONTROLLER_REG_SECONDARY), 16'h1000 + 16'(c));
		for (int c = 0; c < 8; c++) rdchk(ra(c, TRANSFER_CONTROLLER_REG_SECONDARY), 32'h1000 + c);
		$display("test reset done");
	endtask
	task automatic t_one_shot;
		int base;
		int i0;
		bus(1'b1, ra(0, TRANSFER_CONTROLLER_REG_PERIPH_ADDR), 16'h0300);
		bus(1'b1, ra(0, TRANSFER_CONTROLLER_REG_PRIMARY), 16'h0800);
		bus(1'b1, ra(0, TRANSFER_CONTROLLER_REG_LENGTH), 16'h0001);
		bus(1'b1, ra(0, TRANSFER_CONTROLLER_REG_REQUEST), 16'h0005);
		bus(1'b1, ra(0, TRANSFER_CONTROLLER_REG_CONTROL), 16'h8001);
		base = moves;
		i0 = irqs;
		trig(4);
		chk("wrong line", base, moves);
		trig(5);
		trig(5);
		wait_moves(base + 2);
		chk("ram addr", 32'h0802, {16'h0, ram_a});
		chk("irqs", 1, irqs - i0);
		trig(5);
		repeat (8) @(posedge hclk);
		chk("after block", base + 2, moves);
		$display("test one shot done");
	endtask
	task automatic t_force;
		int base;
		bus(1'b1, ra(1, TRANSFER_CONTROLLER_REG_PERIPH_ADDR), 16'h0200);
		bus(1'b1, ra(1, TRANSFER_CONTROLLER_REG_PRIMARY), 16'h0A01);
		bus(1'b1, ra(1, TRANSFER_CONTROLLER_REG_LENGTH), 16'h0000);
		bus(1'b1, ra(1, TRANSFER_CONTROLLER_REG_CONTROL), 16'hE011);
		base = moves;
		bus(1'b1, ra(1, TRANSFER_CONTROLLER_REG_REQUEST), 16'h8000);
		wait_moves(base + 1);
		chk("byte out", 32'h00C2, {16'h0, per_d});
		rdchk(ra(1, TRANSFER_CONTROLLER_REG_REQUEST), 32'h0);
		$display("test force done");
	endtask
	task automatic t_ping_pong;
		int base;
		bus(1'b1, ra(2, TRANSFER_CONTROLLER_REG_PRIMARY), 16'h0900);
		bus(1'b1, ra(2, TRANSFER_CONTROLLER_REG_SECONDARY), 16'h0A00);
		bus(1'b1, ra(2, TRANSFER_CONTROLLER_REG_LENGTH), 16'h0000);
		bus(1'b1, ra(2, TRANSFER_CONTROLLER_REG_REQUEST), 16'h0007);
		bus(1'b1, ra(2, TRANSFER_CONTROLLER_REG_CONTROL), 16'h8802);
		for (int i = 0; i < 3; i++) begin
			base = moves;
			trig(7);
			wait_moves(base + 2);
			chk("buffer", (i == 1) ? 32'h0A00 : 32'h0900, {16'h0, ram_a});
			chk("null data", 32'h0, {16'h0, per_d});
		end
		$display("test ping pong done");
	endtask
	task automatic t_half;
		int base;
		int i0;
		bus(1'b1, ra(3, TRANSFER_CONTROLLER_REG_PRIMARY), 16'h0B00);
		bus(1'b1, ra(3, TRANSFER_CONTROLLER_REG_LENGTH), 16'h0002);
		bus(1'b1, ra(3, TRANSFER_CONTROLLER_REG_REQUEST), 16'h0009);
		bus(1'b1, ra(3, TRANSFER_CONTROLLER_REG_CONTROL), 16'h9020);
		i0 = irqs;
		for (int i = 0; i < 3; i++) begin
			base = moves;
			trig(9);
			wait_moves(base + 1);
			chk("indirect addr", 32'h0B40, {16'h0, ram_a});
			chk("half irq", (i == 0) ? 0 : 1, irqs - i0);
		end
		$display("test half done");
	endtask
	task automatic t_continuous;
		int base;
		int i0;
		bus(1'b1, ra(4, TRANSFER_CONTROLLER_REG_PRIMARY), 16'h0C00);
		bus(1'b1, ra(4, TRANSFER_CONTROLLER_REG_LENGTH), 16'h0000);
		bus(1'b1, ra(4, TRANSFER_CONTROLLER_REG_REQUEST), 16'h000C);
		bus(1'b1, ra(4, TRANSFER_CONTROLLER_REG_CONTROL), 16'h8000);
		for (int i = 0; i < 2; i++) begin
			base = moves;
			i0 = irqs;
			trig(12);
			wait_moves(base + 1);
			chk("reload addr", 32'h0C00, {16'h0, ram_a});
			chk("block irq", 1, irqs - i0);
		end
		rdchk(TRANSFER_CONTROLLER_SHARED_STATUS_ONE, 32'h0404);
		bus(1'b1, ra(4, TRANSFER_CONTROLLER_REG_CONTROL), 16'h0000);
		trig(12);
		trig(12);
		rdchk(TRANSFER_CONTROLLER_SHARED_STATUS_ZERO, 32'h0010);
		bus(1'b1, TRANSFER_CONTROLLER_SHARED_STATUS_ZERO, 16'h0000);
		rdchk(TRANSFER_CONTROLLER_SHARED_STATUS_ZERO, 32'h0);
		$display("test continuous done");
	endtask
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset;
		t_one_shot;
		t_force;
		t_ping_pong;
		t_half;
		t_continuous;
		close_out;
	end
endmodule // transfer_controller_top_tb
`default_nettype wire
